// >>> mfc_pkg.sv
// package for the motor feedback configuration block: object map, reset values, types
package mfc_pkg;

  // ==========================================================================
  // object indices and subindices
  // ==========================================================================
  localparam logic [15:0] MFC_IDX_SENSORLESS = 16'h3380;
  localparam logic [15:0] MFC_IDX_HALL = 16'h3390;
  localparam logic [15:0] MFC_IDX_ENCODER = 16'h33A0;
  localparam logic [7:0] MFC_SUB_COUNT = 8'h00;
  localparam logic [7:0] MFC_SUB_OHMS = 8'h01;
  localparam logic [7:0] MFC_SUB_HENRIES = 8'h02;
  localparam logic [7:0] MFC_SUB_FLUX = 8'h03;
  localparam logic [7:0] MFC_SUB_ENGAGE = 8'h04;
  localparam logic [7:0] MFC_SUB_DISENGAGE = 8'h05;
  localparam logic [7:0] MFC_SUB_HALL_FIRST = 8'h01;
  localparam logic [7:0] MFC_SUB_HALL_LAST = 8'h0C;
  localparam logic [7:0] MFC_SUB_ENC_SETUP = 8'h01;
  localparam logic [7:0] MFC_SUB_ENC_OFFSET = 8'h02;

  // ==========================================================================
  // entry counts, reset values, field positions
  // ==========================================================================
  localparam logic [7:0] MFC_SENSORLESS_COUNT = 8'h05;
  localparam logic [7:0] MFC_HALL_COUNT = 8'h0C;
  localparam logic [7:0] MFC_ENCODER_COUNT = 8'h02;
  localparam logic [31:0] MFC_PARAM_RST = 32'h00000000;
  localparam logic [31:0] MFC_ENGAGE_RST = 32'h00000078;
  localparam logic [31:0] MFC_DISENGAGE_RST = 32'h00000064;
  localparam logic [15:0] MFC_WORD_RST = 16'h0000;
  localparam int MFC_ENC_INDEX_BIT = 0;
  localparam int MFC_HALL_AW = 4;
  localparam int MFC_HALL_ENTRIES = 12;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [3:0] {
    MFC_T_NONE, MFC_T_CNT_SL, MFC_T_OHMS, MFC_T_HENRIES, MFC_T_FLUX, MFC_T_ENGAGE,
    MFC_T_DISENGAGE, MFC_T_CNT_HALL, MFC_T_HALL, MFC_T_CNT_ENC, MFC_T_ENC_SETUP, MFC_T_ENC_OFFSET
  } mfc_target_type;

  // sensorless hysteresis state, one bit so the path is gray by nature
  typedef enum logic {
    MFC_SL_IDLE = 1'b0,
    MFC_SL_RUN = 1'b1
  } mfc_sl_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
  } mfc_obj_req_type;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } mfc_obj_rsp_type;

  typedef struct packed {
    logic active;
    logic [31:0] windingOhms;
    logic [31:0] windingHenries;
    logic [31:0] fluxLinkage;
  } mfc_sensorless_type;

  typedef struct packed {
    logic useIndex;
    logic alignValid;
    logic [15:0] indexOffset;
  } mfc_encoder_type;

endpackage : mfc_pkg

// >>> mfc_align_mem.sv
// twelve-entry hall alignment store with one write port and two registered read ports
`timescale 1ns/1ns
module mfc_align_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // write port
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [15:0] wrData,
  // read port a, control loop
  input wire logic [3:0] rdAddrA,
  output logic [15:0] rdDataA,
  // read port b, object access
  input wire logic [3:0] rdAddrB,
  output logic [15:0] rdDataB
);
  import mfc_pkg::*;

  logic [15:0] entry_q [MFC_HALL_ENTRIES];

  // ==========================================================================
  // storage
  // ==========================================================================
  // flops rather than a ram so every entry clears on reset
  for (genvar i = 0; i < MFC_HALL_ENTRIES; i++) begin : g_entry
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        entry_q[i] <= MFC_WORD_RST;
      end else if (wrEn && wrAddr == 4'(i)) begin
        entry_q[i] <= wrData;
      end
    end
  end

  // ==========================================================================
  // registered reads, out-of-range address reads zero
  // ==========================================================================
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdDataA <= MFC_WORD_RST;
      rdDataB <= MFC_WORD_RST;
    end else begin
      rdDataA <= (rdAddrA < 4'(MFC_HALL_ENTRIES)) ? entry_q[rdAddrA] : MFC_WORD_RST;
      rdDataB <= (rdAddrB < 4'(MFC_HALL_ENTRIES)) ? entry_q[rdAddrB] : MFC_WORD_RST;
    end
  end

endmodule : mfc_align_mem

// >>> mfc_motor_feedback_config.sv
// motor feedback configuration: sensorless, hall and encoder parameter objects
`timescale 1ns/1ns
module mfc_motor_feedback_config (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // object access from the fieldbus side
  input mfc_pkg::mfc_obj_req_type objReq,
  output mfc_pkg::mfc_obj_rsp_type objRsp,
  // result writes from the identification run
  input mfc_pkg::mfc_obj_req_type idReq,
  // control loop status
  input wire logic closedLoop,
  input wire logic sensorsFound,
  input wire logic [31:0] speedRpm,
  input wire logic [3:0] hallStep,
  // parameters handed to the control loop
  output mfc_pkg::mfc_sensorless_type sensorless,
  output logic [15:0] hallOffset,
  output mfc_pkg::mfc_encoder_type encoder
);
  import mfc_pkg::*;

  // ==========================================================================
  // decode of index and subindex into a target
  // ==========================================================================
  function automatic mfc_target_type decodeTarget(input logic [15:0] index, input logic [7:0] sub);
    mfc_target_type t;
    t = MFC_T_NONE;
    if (index == MFC_IDX_SENSORLESS) begin
      unique case (sub)
        MFC_SUB_COUNT: t = MFC_T_CNT_SL;
        MFC_SUB_OHMS: t = MFC_T_OHMS;
        MFC_SUB_HENRIES: t = MFC_T_HENRIES;
        MFC_SUB_FLUX: t = MFC_T_FLUX;
        MFC_SUB_ENGAGE: t = MFC_T_ENGAGE;
        MFC_SUB_DISENGAGE: t = MFC_T_DISENGAGE;
        default: t = MFC_T_NONE;
      endcase
    end else if (index == MFC_IDX_HALL) begin
      if (sub == MFC_SUB_COUNT) begin
        t = MFC_T_CNT_HALL;
      end else if (sub >= MFC_SUB_HALL_FIRST && sub <= MFC_SUB_HALL_LAST) begin
        t = MFC_T_HALL;
      end
    end else if (index == MFC_IDX_ENCODER) begin
      unique case (sub)
        MFC_SUB_COUNT: t = MFC_T_CNT_ENC;
        MFC_SUB_ENC_SETUP: t = MFC_T_ENC_SETUP;
        MFC_SUB_ENC_OFFSET: t = MFC_T_ENC_OFFSET;
        default: t = MFC_T_NONE;
      endcase
    end
    return t;
  endfunction : decodeTarget

  // entry counts are the only read-only targets
  function automatic logic isReadOnly(input mfc_target_type t);
    return (t == MFC_T_CNT_SL) || (t == MFC_T_CNT_HALL) || (t == MFC_T_CNT_ENC);
  endfunction : isReadOnly

  // ==========================================================================
  // declarations
  // ==========================================================================
  // decode and shared write path
  mfc_target_type hostTarget;
  mfc_target_type idTarget;
  mfc_target_type wrTarget;
  logic idWr;
  logic hostWr;
  logic hostErr;
  logic wrEn;
  logic [31:0] wrData;
  logic [7:0] wrSub;
  logic [3:0] hallWrAddr;
  logic [3:0] hallRdAddr;
  logic [15:0] hallRdData;
  logic [31:0] rdValue;
  logic speedAbove;
  logic speedBelow;
  logic hallWrEn;

  // parameter registers
  logic [31:0] ohms_q;
  logic [31:0] henries_q;
  logic [31:0] flux_q;
  logic [31:0] engageRpm_q;
  logic [31:0] disengageRpm_q;
  logic [15:0] encSetup_q;
  logic [15:0] encOffset_q;
  logic encAlignValid_q;
  mfc_sl_state_type slState_q;
  mfc_sl_state_type slState_d;

  // answer registers
  logic rspAck_q;
  logic rspErr_q;
  logic rspHall_q;
  logic [31:0] rspData_q;

  // ==========================================================================
  // write arbitration
  // ==========================================================================
  // the identification run owns the parameters while it writes, so it wins a clash
  always_comb begin
    hostTarget = decodeTarget(objReq.index, objReq.sub);
    idTarget = decodeTarget(idReq.index, idReq.sub);
  end

  // a write needs a mapped, writable target; the host yields to the identification run
  always_comb begin
    idWr = idReq.valid && idReq.write && idTarget != MFC_T_NONE && !isReadOnly(idTarget);
    hostWr = objReq.valid && objReq.write && hostTarget != MFC_T_NONE && !isReadOnly(hostTarget) && !idWr;
    wrEn = idWr || hostWr;
  end

  // one shared write path keeps every register single-driven
  always_comb begin
    if (idWr) begin
      wrTarget = idTarget;
      wrData = idReq.wdata;
      wrSub = idReq.sub;
    end else begin
      wrTarget = hostTarget;
      wrData = objReq.wdata;
      wrSub = objReq.sub;
    end
  end

  // error cases: unknown object, write to a count entry, write lost to the identification run
  always_comb begin
    hostErr = 1'b0;
    if (hostTarget == MFC_T_NONE) begin
      hostErr = 1'b1;
    end else if (objReq.write && isReadOnly(hostTarget)) begin
      hostErr = 1'b1;
    end else if (objReq.write && idWr) begin
      hostErr = 1'b1;
    end
  end

  // ==========================================================================
  // sensorless parameter set
  // ==========================================================================
  // float values are held as raw bit patterns, the loop does the arithmetic
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ohms_q <= MFC_PARAM_RST;
      henries_q <= MFC_PARAM_RST;
      flux_q <= MFC_PARAM_RST;
    end else if (wrEn) begin
      if (wrTarget == MFC_T_OHMS) begin
        ohms_q <= wrData;
      end
      if (wrTarget == MFC_T_HENRIES) begin
        henries_q <= wrData;
      end
      if (wrTarget == MFC_T_FLUX) begin
        flux_q <= wrData;
      end
    end
  end

  // engage and disengage thresholds in rpm
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      engageRpm_q <= MFC_ENGAGE_RST;
      disengageRpm_q <= MFC_DISENGAGE_RST;
    end else if (wrEn) begin
      if (wrTarget == MFC_T_ENGAGE) begin
        engageRpm_q <= wrData;
      end
      if (wrTarget == MFC_T_DISENGAGE) begin
        disengageRpm_q <= wrData;
      end
    end
  end

  // ==========================================================================
  // sensorless engage state
  // ==========================================================================
  // strict comparisons, so with engage above disengage a speed equal to a threshold never moves the state
  always_comb begin
    speedAbove = speedRpm > engageRpm_q;
    speedBelow = speedRpm < disengageRpm_q;
  end

  // thresholds written the wrong way round leave no band, so a speed between them toggles the state every cycle; nothing guards it
  always_comb begin
    slState_d = slState_q;
    if (!closedLoop || sensorsFound) begin
      slState_d = MFC_SL_IDLE;
    end else begin
      unique case (slState_q)
        MFC_SL_IDLE: begin
          if (speedAbove) begin
            slState_d = MFC_SL_RUN;
          end
        end
        MFC_SL_RUN: begin
          if (speedBelow) begin
            slState_d = MFC_SL_IDLE;
          end
        end
      endcase
    end
  end

  // held in the band between thresholds
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      slState_q <= MFC_SL_IDLE;
    end else begin
      slState_q <= slState_d;
    end
  end

  // parameter set travels with the engage flag
  always_comb begin
    sensorless.active = (slState_q == MFC_SL_RUN);
    sensorless.windingOhms = ohms_q;
    sensorless.windingHenries = henries_q;
    sensorless.fluxLinkage = flux_q;
  end

  // ==========================================================================
  // hall alignment table
  // ==========================================================================
  // subindex 1..12 maps onto entry 0..11
  always_comb begin
    hallWrAddr = 4'(wrSub - MFC_SUB_HALL_FIRST);
    hallRdAddr = 4'(objReq.sub - MFC_SUB_HALL_FIRST);
    hallWrEn = wrEn && wrTarget == MFC_T_HALL;
  end

  mfc_align_mem u_align_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .wrEn(hallWrEn),
    .wrAddr(hallWrAddr),
    .wrData(wrData[15:0]),
    .rdAddrA(hallStep),
    .rdDataA(hallOffset),
    .rdAddrB(hallRdAddr),
    .rdDataB(hallRdData)
  );

  // ==========================================================================
  // incremental encoder setup
  // ==========================================================================
  // whole setup word kept so later bits can be given meaning without a new object
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      encSetup_q <= MFC_WORD_RST;
      encOffset_q <= MFC_WORD_RST;
    end else if (wrEn) begin
      if (wrTarget == MFC_T_ENC_SETUP) begin
        encSetup_q <= wrData[15:0];
      end
      if (wrTarget == MFC_T_ENC_OFFSET) begin
        encOffset_q <= wrData[15:0];
      end
    end
  end

  // alignment counts as supplied once anyone writes it; only reset withdraws it
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      encAlignValid_q <= 1'b0;
    end else if (wrEn && wrTarget == MFC_T_ENC_OFFSET) begin
      encAlignValid_q <= 1'b1;
    end
  end

  // encoder view handed to the control loop
  always_comb begin
    encoder.useIndex = encSetup_q[MFC_ENC_INDEX_BIT];
    encoder.indexOffset = encOffset_q;
    encoder.alignValid = encAlignValid_q;
  end

  // ==========================================================================
  // read data selection
  // ==========================================================================
  // reads see the value before any write of the same cycle
  always_comb begin
    unique case (hostTarget)
      MFC_T_CNT_SL: rdValue = {24'h000000, MFC_SENSORLESS_COUNT};
      MFC_T_OHMS: rdValue = ohms_q;
      MFC_T_HENRIES: rdValue = henries_q;
      MFC_T_FLUX: rdValue = flux_q;
      MFC_T_ENGAGE: rdValue = engageRpm_q;
      MFC_T_DISENGAGE: rdValue = disengageRpm_q;
      MFC_T_CNT_HALL: rdValue = {24'h000000, MFC_HALL_COUNT};
      MFC_T_CNT_ENC: rdValue = {24'h000000, MFC_ENCODER_COUNT};
      MFC_T_ENC_SETUP: rdValue = {16'h0000, encSetup_q};
      MFC_T_ENC_OFFSET: rdValue = {16'h0000, encOffset_q};
      default: rdValue = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // answer to the object port
  // ==========================================================================
  // every request is answered one cycle later, reads and writes alike
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rspAck_q <= 1'b0;
      rspErr_q <= 1'b0;
      rspHall_q <= 1'b0;
      rspData_q <= 32'h00000000;
    end else begin
      rspAck_q <= objReq.valid;
      rspErr_q <= objReq.valid && hostErr;
      rspHall_q <= objReq.valid && !objReq.write && hostTarget == MFC_T_HALL;
      if (objReq.valid && !objReq.write && !hostErr) begin
        rspData_q <= rdValue;
      end else begin
        rspData_q <= 32'h00000000;
      end
    end
  end

  // hall words come from the memory's own output register
  always_comb begin
    objRsp.ack = rspAck_q;
    objRsp.err = rspErr_q;
    objRsp.rdata = rspHall_q ? {16'h0000, hallRdData} : rspData_q;
  end

endmodule : mfc_motor_feedback_config

// >>> mfc_motor_feedback_config_asserts.sv
// assertion checker for the motor feedback configuration block
`timescale 1ns/1ns
module mfc_config_checker
  import mfc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // object and identification ports
  input mfc_pkg::mfc_obj_req_type objReq,
  input mfc_pkg::mfc_obj_rsp_type objRsp,
  input mfc_pkg::mfc_obj_req_type idReq,
  // control loop side
  input wire logic closedLoop,
  input wire logic sensorsFound,
  input wire logic [31:0] speedRpm,
  input wire logic [3:0] hallStep,
  input mfc_pkg::mfc_sensorless_type sensorless,
  input wire logic [15:0] hallOffset,
  input mfc_pkg::mfc_encoder_type encoder
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // threshold shadow
  // ==========================================================================
  logic [31:0] engQ;
  logic [31:0] disQ;
  mfc_obj_req_type w;
  // id writes win, so a host write in the same cycle must not move the shadow
  assign w = (idReq.valid && idReq.write) ? idReq : objReq;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      engQ <= MFC_ENGAGE_RST;
      disQ <= MFC_DISENGAGE_RST;
    end else if (w.valid && w.write && w.index == MFC_IDX_SENSORLESS) begin
      if (w.sub == MFC_SUB_ENGAGE) engQ <= w.wdata;
      if (w.sub == MFC_SUB_DISENGAGE) disQ <= w.wdata;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  a_ack_follows_req: assert property (objReq.valid |=> objRsp.ack ##1 (objRsp.ack == $past(objReq.valid)))
    else $error("object request not answered in one cycle");
  a_no_stray_ack: assert property (!objReq.valid |=> !objRsp.ack && objRsp.rdata == 32'h00000000)
    else $error("answer without request");
  a_hall_count_read: assert property (objReq.valid && !objReq.write && objReq.index == MFC_IDX_HALL
    && objReq.sub == MFC_SUB_COUNT |=> objRsp.rdata == 32'h0000000C && !objRsp.err)
    else $error("hall entry count wrong");
  a_engage_above: assert property (closedLoop && !sensorsFound && speedRpm > engQ |=> sensorless.active)
    else $error("sensorless did not engage");
  a_drop_below: assert property (speedRpm < disQ |=> !sensorless.active)
    else $error("sensorless did not disengage");
  a_band_holds: assert property (closedLoop && !sensorsFound && speedRpm >= disQ && speedRpm <= engQ
    |=> $stable(sensorless.active))
    else $error("sensorless state moved inside band");
  a_open_loop_off: assert property (!closedLoop || sensorsFound |=> !sensorless.active)
    else $error("sensorless active outside its mode");
  a_hall_range_zero: assert property (hallStep >= 4'hC |=> hallOffset == 16'h0000)
    else $error("hall lookup out of range not zero");
  a_index_flag_bit: assert property (idReq.valid && idReq.write && idReq.index == MFC_IDX_ENCODER
    && idReq.sub == MFC_SUB_ENC_SETUP |=> encoder.useIndex == $past(idReq.wdata[0]))
    else $error("index flag not taken from bit 0");
  a_align_offset_set: assert property (idReq.valid && idReq.write && idReq.index == MFC_IDX_ENCODER
    && idReq.sub == MFC_SUB_ENC_OFFSET |=> encoder.alignValid && encoder.indexOffset == $past(idReq.wdata[15:0]))
    else $error("alignment word not taken");

  // main scenarios reached
  c_engaged: cover property ($rose(sensorless.active));
  c_refused: cover property (objRsp.err);
  c_hall_lookup: cover property (hallOffset != 16'h0000);
endmodule : mfc_config_checker

bind mfc_motor_feedback_config mfc_config_checker u_chk (.mclk(mclk), .arst_n(arst_n), .objReq(objReq),
  .objRsp(objRsp), .idReq(idReq), .closedLoop(closedLoop), .sensorsFound(sensorsFound), .speedRpm(speedRpm),
  .hallStep(hallStep), .sensorless(sensorless), .hallOffset(hallOffset), .encoder(encoder));

// >>> mfc_motor_model.sv
// behavioural motor: speed and hall position as the sensors report them
`timescale 1ns/1ns
module mfc_motor_model (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // commanded motion
  input wire logic [31:0] targetRpm,
  input wire logic [3:0] targetStep,
  // sensed motion
  output logic [31:0] speedRpm,
  output logic [3:0] hallStep
);
  // sensors lag the motion by one sample, as a sampled tachometer would
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      speedRpm <= 32'h00000000;
      hallStep <= 4'h0;
    end else begin
      speedRpm <= targetRpm;
      hallStep <= targetStep;
    end
  end
endmodule : mfc_motor_model

// >>> mfc_motor_feedback_config_tb.sv
// self-checking testbench for the motor feedback configuration block
`timescale 1ns/1ns
module mfc_motor_feedback_config_tb;
  import mfc_pkg::*;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic mclk;
  logic arst_n;
  logic closedLoop;
  logic sensorsFound;
  mfc_obj_req_type objReq;
  mfc_obj_req_type idReq;
  mfc_obj_rsp_type objRsp;
  mfc_sensorless_type sensorless;
  mfc_encoder_type encoder;
  logic [31:0] speedRpm;
  logic [31:0] targetRpm;
  logic [3:0] hallStep;
  logic [3:0] targetStep;
  logic [15:0] hallOffset;
  int miscompares = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [31:0] slRst [6] = '{32'h00000005, 32'h00000000, 32'h00000000, 32'h00000000, 32'h00000078, 32'h00000064};
  logic [31:0] rpmSeq [10] = '{32'h78, 32'h79, 32'h6E, 32'h64, 32'h63, 32'h6E, 32'h78, 32'h79, 32'h6E, 32'h63};
  logic expSeq [10] = '{0, 1, 1, 1, 0, 0, 0, 1, 1, 0};

  mfc_motor_feedback_config DUT (.mclk(mclk), .arst_n(arst_n), .objReq(objReq), .objRsp(objRsp), .idReq(idReq),
    .closedLoop(closedLoop), .sensorsFound(sensorsFound), .speedRpm(speedRpm), .hallStep(hallStep),
    .sensorless(sensorless), .hallOffset(hallOffset), .encoder(encoder));
  mfc_motor_model u_motor (.mclk(mclk), .arst_n(arst_n), .targetRpm(targetRpm), .targetStep(targetStep),
    .speedRpm(speedRpm), .hallStep(hallStep));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // inputs move 1 ns after the edge so no race with the sampling edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  // one host access; the answer stands one cycle, so look at it right after the edge
  task automatic obj(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                     input logic expErr, input logic [31:0] expRd);
    objReq = {1'b1, wr, idx, sub, wd};
    step(1);
    chk({31'h0, objRsp.ack}, 32'h00000001);
    chk({31'h0, objRsp.err}, {31'h0, expErr});
    if (!wr) chk(objRsp.rdata, expRd);
    objReq = '0;
    idReq = '0;
    step(1);
  endtask : obj

  task automatic idw(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
    idReq = {1'b1, 1'b1, idx, sub, wd};
    step(1);
    idReq = '0;
    step(1);
  endtask : idw

  // speed reaches the block one edge later, the state one edge after that
  task automatic spin(input logic [31:0] rpm, input logic exp);
    targetRpm = rpm;
    step(3);
    chk({31'h0, sensorless.active}, {31'h0, exp});
  endtask : spin

  // hang guard, generous against the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ==========================================================================
  // sequence
  // ==========================================================================
  initial begin
    arst_n = 1'b0;
    closedLoop = 1'b0;
    sensorsFound = 1'b0;
    objReq = '0;
    idReq = '0;
    targetRpm = 32'h00000000;
    targetStep = 4'h0;
    repeat (10) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    step(1);
    // reset values and entry counts
    for (int s = 0; s < 6; s++)
      obj(1'b0, MFC_IDX_SENSORLESS, 8'(s), 32'h0, 1'b0, slRst[s]);
    for (int s = 0; s < 13; s++)
      obj(1'b0, MFC_IDX_HALL, 8'(s), 32'h0, 1'b0, (s == 0) ? 32'h0000000C : 32'h0);
    for (int s = 0; s < 3; s++)
      obj(1'b0, MFC_IDX_ENCODER, 8'(s), 32'h0, 1'b0, (s == 0) ? 32'h00000002 : 32'h0);
    chk({31'h0, encoder.alignValid}, 32'h0);
    // back to back reads, one answer per request
    objReq = {1'b1, 1'b0, MFC_IDX_SENSORLESS, MFC_SUB_ENGAGE, 32'h0};
    step(1);
    objReq = {1'b1, 1'b0, MFC_IDX_SENSORLESS, MFC_SUB_DISENGAGE, 32'h0};
    chk(objRsp.rdata, 32'h00000078);
    step(1);
    objReq = '0;
    chk(objRsp.rdata, 32'h00000064);
    step(1);
    // motor constants kept whole and handed to the loop
    for (int s = 1; s < 4; s++) begin
      obj(1'b1, MFC_IDX_SENSORLESS, 8'(s), 32'hC0A80000 + s, 1'b0, 32'h0);
      obj(1'b0, MFC_IDX_SENSORLESS, 8'(s), 32'h0, 1'b0, 32'hC0A80000 + s);
    end
    chk(sensorless.fluxLinkage, 32'hC0A80003);
    chk(sensorless.windingOhms, 32'hC0A80001);
    chk(sensorless.windingHenries, 32'hC0A80002);
    // hall table: upper bits dropped, lookup by step, beyond twelve reads zero
    for (int k = 1; k < 13; k++)
      obj(1'b1, MFC_IDX_HALL, 8'(k), 32'hFFFF0000 | (k * 32'h111), 1'b0, 32'h0);
    obj(1'b0, MFC_IDX_HALL, 8'h0C, 32'h0, 1'b0, 32'h00000CCC);
    for (int k = 0; k < 14; k++) begin
      targetStep = 4'(k);
      step(3);
      chk({16'h0, hallOffset}, (k < 12) ? (k + 1) * 32'h111 : 32'h0);
    end
    // refused accesses change nothing
    obj(1'b1, MFC_IDX_SENSORLESS, MFC_SUB_COUNT, 32'h7, 1'b1, 32'h0);
    obj(1'b0, 16'h3381, 8'h00, 32'h0, 1'b1, 32'h0);
    obj(1'b1, MFC_IDX_HALL, 8'h0D, 32'h5, 1'b1, 32'h0);
    obj(1'b0, MFC_IDX_SENSORLESS, MFC_SUB_COUNT, 32'h0, 1'b0, 32'h00000005);
    // encoder index flag and alignment
    idw(MFC_IDX_ENCODER, MFC_SUB_ENC_SETUP, 32'hFFFF0001);
    chk({31'h0, encoder.useIndex}, 32'h1);
    idw(MFC_IDX_ENCODER, MFC_SUB_ENC_SETUP, 32'h00000002);
    chk({31'h0, encoder.useIndex}, 32'h0);
    obj(1'b1, MFC_IDX_ENCODER, MFC_SUB_ENC_OFFSET, 32'h00002BAD, 1'b0, 32'h0);
    chk({15'h0, encoder.alignValid, encoder.indexOffset}, 32'h00012BAD);
    // identification write wins over the host in the same cycle
    idReq = {1'b1, 1'b1, MFC_IDX_ENCODER, MFC_SUB_ENC_OFFSET, 32'h00001357};
    obj(1'b1, MFC_IDX_ENCODER, MFC_SUB_ENC_OFFSET, 32'h00002468, 1'b1, 32'h0);
    obj(1'b0, MFC_IDX_ENCODER, MFC_SUB_ENC_OFFSET, 32'h0, 1'b0, 32'h00001357);
    // hysteresis with default thresholds, equal values hold
    closedLoop = 1'b1;
    for (int i = 0; i < 10; i++)
      spin(rpmSeq[i], expSeq[i]);
    // moved thresholds, host and identification paths
    obj(1'b1, MFC_IDX_SENSORLESS, MFC_SUB_ENGAGE, 32'h000000C8, 1'b0, 32'h0);
    spin(32'h000000C8, 1'b0);
    spin(32'h000000C9, 1'b1);
    idw(MFC_IDX_SENSORLESS, MFC_SUB_DISENGAGE, 32'h00000096);
    spin(32'h00000096, 1'b1);
    spin(32'h00000095, 1'b0);
    // sensors present or open loop keep it off
    spin(32'h000000FA, 1'b1);
    sensorsFound = 1'b1;
    spin(32'h000000FA, 1'b0);
    sensorsFound = 1'b0;
    closedLoop = 1'b0;
    spin(32'h000000FA, 1'b0);
    // reset mid-run withdraws the alignment and restores the engage threshold
    arst_n = 1'b0;
    step(2);
    arst_n = 1'b1;
    step(1);
    chk({31'h0, encoder.alignValid}, 32'h0);
    obj(1'b0, MFC_IDX_SENSORLESS, MFC_SUB_ENGAGE, 32'h0, 1'b0, 32'h00000078);
    give_verdict();
  end
endmodule : mfc_motor_feedback_config_tb
